// *** logic/uart_status_baud.sv ***
// Per-channel line/modem status, scratch, divisor and baud tick generator
module uart_status_baud
   import uart_status_baud_pkg::*;
(
   // Clock and resets
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       por_n,
   // Register port
   input  wire logic [2:0] addr,
   input  wire logic       rd_en,
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_data,
   output logic      [7:0] rd_data,
   // Control registers held elsewhere in the channel
   input  wire logic [7:0] line_control,
   input  wire logic [7:0] modem_control,
   input  wire logic [7:0] enhanced_feature_control,
   input  wire logic       modem_int_enable,
   // Receive datapath status
   input  wire logic       rx_fifo_nonempty,
   input  wire logic       rx_fifo_full,
   input  wire logic       rx_char_arrived,
   input  wire logic       rx_head_parity_err,
   input  wire logic       rx_head_framing_err,
   input  wire logic       rx_head_break,
   input  wire logic       rx_any_error,
   // Modem inputs, active low
   input  wire logic       clear_to_send_n,
   input  wire logic       data_set_ready_n,
   input  wire logic       ring_indicator_n,
   input  wire logic       carrier_detect_n,
   // Datapath controls
   output logic            rx_fifo_write,
   output logic            irda_mode,
   output logic            rs485_auto,
   output logic            sample_tick,
   output logic            modem_irq
);
   logic       rst_a_ff, rst_s_ff, por_a_ff, por_s_ff;
   logic [7:0] div_low_ff, div_high_ff, rate_mode_ff, scratch_ff;
   logic       overrun_ff, dcts_ff, ddsr_ff;
   logic       cts_prev_ff, dsr_prev_ff, first_ff;
   logic [15:0] div_cnt_ff;
   logic [1:0]  pre_cnt_ff;
   logic [4:0]  osr_cnt_ff;
   logic [7:0]  line_state, modem_state;
   logic        sel_div, sel_rate, sel_alt, cts_lvl, dsr_lvl, ri_lvl, cd_lvl;
   logic        loop;
   logic [4:0]  osr_max;

   // Two-stage release of both resets; por_n is power-on only
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_a_ff <= 1'b0;
         rst_s_ff <= 1'b0;
      end else begin
         rst_a_ff <= 1'b1;
         rst_s_ff <= rst_a_ff;
      end
   end
   always_ff @(posedge clk or negedge por_n) begin
      if (!por_n) begin
         por_a_ff <= 1'b0;
         por_s_ff <= 1'b0;
      end else begin
         por_a_ff <= 1'b1;
         por_s_ff <= por_a_ff;
      end
   end

   // Address window decode
   assign sel_div  = line_control[LC_DLAB]
                     && (line_control != ENH_ACCESS_CODE);
   assign sel_rate = enhanced_feature_control[EF_ENH]
                     && line_control[LC_DLAB];
   assign sel_alt  = !line_control[LC_DLAB]
                     && !modem_control[MC_ALT_SEL];
   assign loop     = modem_control[MC_LOOP];

   // Loopback substitution; DSR/CTS loop from outputs not modelled here
   assign cts_lvl = !clear_to_send_n;
   assign dsr_lvl = !data_set_ready_n;
   assign ri_lvl  = loop ? modem_control[MC_OP1]
                         : !ring_indicator_n;
   assign cd_lvl  = loop ? modem_control[MC_OP2]
                         : !carrier_detect_n;

   always_comb begin
      line_state = 8'h00;
      line_state[LS_READY]    = rx_fifo_nonempty;
      line_state[LS_OVERRUN]  = overrun_ff;
      line_state[LS_PARITY]   = rx_fifo_nonempty && rx_head_parity_err;
      line_state[LS_FRAMING]  = rx_fifo_nonempty && rx_head_framing_err;
      line_state[LS_BREAK]    = rx_fifo_nonempty && rx_head_break;
      line_state[LS_FIFO_ERR] = rx_any_error;
   end

   // Upper bits are inverted pin levels (RI/CD take OP1/OP2 in loop), so reset shows inverted pins
   always_comb begin
      modem_state = {cd_lvl, ri_lvl, dsr_lvl, cts_lvl,
                     2'b00, ddsr_ff, dcts_ff};
   end

   // Overrun: set on arrival into a full FIFO, cleared by reading; set wins
   always_ff @(posedge clk or negedge rst_s_ff) begin
      if (!rst_s_ff) begin
         overrun_ff <= 1'b0;
      end else if (rx_char_arrived && rx_fifo_full) begin
         overrun_ff <= 1'b1;
      end else if (rd_en && addr == OFS_RX_STATE
                   && !line_control[LC_DLAB]) begin
         overrun_ff <= 1'b0;
      end
   end

   // Dropped byte never reaches the FIFO
   always_ff @(posedge clk or negedge rst_s_ff) begin
      if (!rst_s_ff) begin
         rx_fifo_write <= 1'b0;
      end else begin
         rx_fifo_write <= rx_char_arrived && !rx_fifo_full;
      end
   end

   // Delta flags; first cycle after reset only captures levels
   always_ff @(posedge clk or negedge rst_s_ff) begin
      if (!rst_s_ff) begin
         first_ff    <= 1'b1;
         cts_prev_ff <= 1'b0;
         dsr_prev_ff <= 1'b0;
         dcts_ff     <= 1'b0;
         ddsr_ff     <= 1'b0;
      end else begin
         first_ff    <= 1'b0;
         cts_prev_ff <= cts_lvl;
         dsr_prev_ff <= dsr_lvl;
         if (!first_ff && cts_lvl != cts_prev_ff) begin
            dcts_ff <= 1'b1;
         end else if (rd_en && addr == OFS_MODEM && sel_alt) begin
            dcts_ff <= 1'b0;
         end
         if (!first_ff && dsr_lvl != dsr_prev_ff) begin
            ddsr_ff <= 1'b1;
         end else if (rd_en && addr == OFS_MODEM && sel_alt) begin
            ddsr_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_s_ff) begin
      if (!rst_s_ff) begin
         modem_irq <= 1'b0;
      end else begin
         modem_irq <= modem_int_enable && (dcts_ff || ddsr_ff);
      end
   end

   // Scratch: no sleep input touches it, so contents survive sleep
   always_ff @(posedge clk or negedge rst_s_ff) begin
      if (!rst_s_ff) begin
         scratch_ff <= RST_SCRATCH;
      end else if (wr_en && addr == OFS_SCRATCH && sel_alt) begin
         scratch_ff <= wr_data;
      end
   end

   // Divisor survives ordinary reset; only power-on reloads it, to 0001
   always_ff @(posedge clk or negedge por_s_ff) begin
      if (!por_s_ff) begin
         div_low_ff  <= RST_DIV_LOW;
         div_high_ff <= RST_DIV_HIGH;
      end else if (wr_en && sel_div) begin
         if (addr == OFS_DIV_LOW) begin
            div_low_ff <= wr_data;
         end
         if (addr == OFS_DIV_HIGH) begin
            div_high_ff <= wr_data;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_s_ff) begin
      if (!rst_s_ff) begin
         rate_mode_ff <= RST_RATE_MODE;
      end else if (wr_en && sel_rate && addr == OFS_RATE_MODE) begin
         rate_mode_ff <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_s_ff) begin
      if (!rst_s_ff) begin
         irda_mode  <= 1'b0;
         rs485_auto <= 1'b0;
      end else begin
         irda_mode  <= rate_mode_ff[RM_IRDA];
         rs485_auto <= rate_mode_ff[RM_RS485];
      end
   end

   // Read mux; rate/mode takes offset 2 over the shared window
   always_ff @(posedge clk or negedge rst_s_ff) begin
      if (!rst_s_ff) begin
         rd_data <= 8'h00;
      end else if (rd_en) begin
         rd_data <= 8'h00;
         if (sel_div && addr == OFS_DIV_LOW) begin
            rd_data <= div_low_ff;
         end else if (sel_div && addr == OFS_DIV_HIGH) begin
            rd_data <= div_high_ff;
         end else if (sel_rate && addr == OFS_RATE_MODE) begin
            rd_data <= rate_mode_ff;
         end else if (!line_control[LC_DLAB] && addr == OFS_RX_STATE) begin
            rd_data <= line_state;
         end else if (sel_alt && addr == OFS_MODEM) begin
            rd_data <= modem_state;
         end else if (sel_alt && addr == OFS_SCRATCH) begin
            rd_data <= scratch_ff;
         end
      end
   end

   // Oversampling factor select
   always_comb begin
      if (rate_mode_ff[RM_RATE_HI]) begin
         osr_max = OSR_4;
      end else if (rate_mode_ff[RM_RATE_LO]) begin
         osr_max = OSR_8;
      end else begin
         osr_max = OSR_16;
      end
   end

   // Chain: divisor -> prescaler -> tick; divisor 0 treated as 1
   always_ff @(posedge clk or negedge rst_s_ff) begin
      if (!rst_s_ff) begin
         div_cnt_ff  <= 16'h0000;
         pre_cnt_ff  <= 2'h0;
         osr_cnt_ff  <= 5'h00;
         sample_tick <= 1'b0;
      end else begin
         sample_tick <= 1'b0;
         if (div_cnt_ff + 16'h0001 >= {div_high_ff, div_low_ff}) begin
            div_cnt_ff <= 16'h0000;
            if (!modem_control[MC_PRESCALE]
                || pre_cnt_ff == PRESCALE_DIV) begin
               pre_cnt_ff  <= 2'h0;
               sample_tick <= 1'b1;
               osr_cnt_ff  <= (osr_cnt_ff >= osr_max) ? 5'h00
                              : osr_cnt_ff + 5'h01;
            end else begin
               pre_cnt_ff <= pre_cnt_ff + 2'h1;
            end
         end else begin
            div_cnt_ff <= div_cnt_ff + 16'h0001;
         end
      end
   end

   // Checks
   property p_div_reset;
      @(posedge clk) $rose(por_s_ff) |-> div_low_ff == RST_DIV_LOW;
   endproperty
   a_div_reset: assert property (p_div_reset)
      else $error("divisor default wrong");
   property p_scratch_wr;
      @(posedge clk) disable iff (!rst_s_ff)
      wr_en && addr == OFS_SCRATCH && sel_alt |=> scratch_ff == $past(wr_data);
   endproperty
   a_scratch_wr: assert property (p_scratch_wr)
      else $error("scratch write lost");
   property p_overrun;
      @(posedge clk) disable iff (!rst_s_ff)
      rx_char_arrived && rx_fifo_full |=> overrun_ff && !rx_fifo_write;
   endproperty
   a_overrun: assert property (p_overrun)
      else $error("overrun not flagged");
   property p_dcts;
      @(posedge clk) disable iff (!rst_s_ff)
      !first_ff && $changed(cts_lvl) |=> dcts_ff;
   endproperty
   a_dcts: assert property (p_dcts)
      else $error("cts delta missed");
   property p_irq;
      @(posedge clk) disable iff (!rst_s_ff)
      modem_int_enable && ddsr_ff |=> modem_irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("modem irq missing");
   property p_ri_loop;
      @(posedge clk) disable iff (!rst_s_ff)
      loop |-> modem_state[MS_RI] == modem_control[MC_OP1];
   endproperty
   a_ri_loop: assert property (p_ri_loop)
      else $error("ri loop wrong");
   property p_cd_pin;
      @(posedge clk) disable iff (!rst_s_ff)
      !loop |-> modem_state[MS_CD] == !carrier_detect_n;
   endproperty
   a_cd_pin: assert property (p_cd_pin)
      else $error("cd pin wrong");
   property p_tick_gap;
      @(posedge clk) disable iff (!rst_s_ff)
      sample_tick && {div_high_ff, div_low_ff} == 16'h0002
      && !modem_control[MC_PRESCALE] && $stable(div_low_ff)
      |=> !sample_tick;
   endproperty
   a_tick_gap: assert property (p_tick_gap)
      else $error("tick too early");
   property p_osr_wrap;
      @(posedge clk) disable iff (!rst_s_ff)
      sample_tick && $past(osr_cnt_ff) >= $past(osr_max)
      |-> osr_cnt_ff == 5'h00;
   endproperty
   a_osr_wrap: assert property (p_osr_wrap)
      else $error("sample counter missed wrap");
   property p_div_refuse;
      @(posedge clk) disable iff (!por_s_ff)
      wr_en && addr == OFS_DIV_LOW && line_control == ENH_ACCESS_CODE
      |=> $stable(div_low_ff);
   endproperty
   a_div_refuse: assert property (p_div_refuse)
      else $error("divisor written under enhanced code");
   property p_rx_ready;
      @(posedge clk) disable iff (!rst_s_ff)
      rd_en && addr == OFS_RX_STATE && !line_control[LC_DLAB]
      |=> rd_data[LS_READY] == $past(rx_fifo_nonempty);
   endproperty
   a_rx_ready: assert property (p_rx_ready)
      else $error("receive ready bit wrong");
   property p_alt_refuse;
      @(posedge clk) disable iff (!rst_s_ff)
      rd_en && addr == OFS_SCRATCH && !sel_alt |=> rd_data == 8'h00;
   endproperty
   a_alt_refuse: assert property (p_alt_refuse)
      else $error("scratch read outside window");
   property p_irda;
      @(posedge clk) disable iff (!rst_s_ff)
      rate_mode_ff[RM_IRDA] != irda_mode
      |=> irda_mode == $past(rate_mode_ff[RM_IRDA]);
   endproperty
   a_irda: assert property (p_irda)
      else $error("infrared mode not following register");
   property p_ri_pin;
      @(posedge clk) disable iff (!rst_s_ff)
      !loop |-> modem_state[MS_RI] == !ring_indicator_n;
   endproperty
   a_ri_pin: assert property (p_ri_pin)
      else $error("ri pin wrong");
   c_tick:    cover property (@(posedge clk) sample_tick);
   c_overrun: cover property (@(posedge clk) overrun_ff);
   c_irq:     cover property (@(posedge clk) modem_irq);
   c_osr:     cover property (@(posedge clk) osr_cnt_ff == osr_max);
   c_loop:    cover property (@(posedge clk) loop);
endmodule // uart_status_baud

// *** logic/uart_status_baud_pkg.sv ***
// Register map, field positions and reset values of the status/baud slice
package uart_status_baud_pkg;
   localparam logic [2:0] OFS_DIV_LOW   = 3'h0;
   localparam logic [2:0] OFS_DIV_HIGH  = 3'h1;
   localparam logic [2:0] OFS_RATE_MODE = 3'h2;
   localparam logic [2:0] OFS_RX_STATE  = 3'h5;
   localparam logic [2:0] OFS_MODEM     = 3'h6;
   localparam logic [2:0] OFS_SCRATCH   = 3'h7;
   localparam logic [7:0] ENH_ACCESS_CODE = 8'hBF;
   localparam logic [7:0] RST_DIV_LOW   = 8'h01;
   localparam logic [7:0] RST_DIV_HIGH  = 8'h00;
   localparam logic [7:0] RST_RATE_MODE = 8'h00;
   localparam logic [7:0] RST_SCRATCH   = 8'hFF;
   localparam int LC_DLAB     = 7;
   localparam int MC_LOOP     = 4;
   localparam int MC_OP1      = 2;
   localparam int MC_OP2      = 3;
   localparam int MC_ALT_SEL  = 6;
   localparam int MC_PRESCALE = 7;
   localparam int EF_ENH      = 4;
   localparam int RM_IRDA     = 7;
   localparam int RM_RS485    = 6;
   localparam int RM_RATE_HI  = 5;
   localparam int RM_RATE_LO  = 4;
   localparam int LS_READY    = 0;
   localparam int LS_OVERRUN  = 1;
   localparam int LS_PARITY   = 2;
   localparam int LS_FRAMING  = 3;
   localparam int LS_BREAK    = 4;
   localparam int LS_FIFO_ERR = 7;
   localparam int MS_DCTS     = 0;
   localparam int MS_DDSR     = 1;
   localparam int MS_RI       = 6;
   localparam int MS_CD       = 7;
   localparam logic [1:0] PRESCALE_DIV = 2'h3;
   localparam logic [4:0] OSR_16 = 5'h0F;
   localparam logic [4:0] OSR_8  = 5'h07;
   localparam logic [4:0] OSR_4  = 5'h03;
endpackage

// *** testbench/uart_host_model.sv ***
// Host processor model driving the register port of the status/baud slice
module uart_host_model (
   // Clock
   input  wire logic       clk,
   // Register port
   output logic      [2:0] addr,
   output logic            rd_en,
   output logic            wr_en,
   output logic      [7:0] wr_data,
   input  wire logic [7:0] rd_data
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      addr = 3'h0;
      rd_en = 1'b0;
      wr_en = 1'b0;
      wr_data = 8'h00;
   end

   // Strobe held for exactly the edge that takes it, so no double access
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      wr_data <= ~d;
   endtask

   // Registered read data stands until the next read; take it one edge on
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      @(posedge clk);
      d = rd_data;
   endtask
endmodule // uart_host_model

// *** testbench/uart_status_baud_test.sv ***
// Self-checking bench for the status/baud register slice
module uart_status_baud_test
   import uart_status_baud_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic       clk, reset_n, por_n, rd_en, wr_en, modem_int_enable;
   logic [2:0] addr;
   logic [7:0] wr_data, rd_data, r, v;
   logic [7:0] line_control, modem_control, enhanced_feature_control;
   logic       rx_fifo_nonempty, rx_fifo_full, rx_char_arrived;
   logic       rx_head_parity_err, rx_head_framing_err, rx_head_break;
   logic       rx_any_error, rx_fifo_write, irda_mode, rs485_auto;
   logic       clear_to_send_n, data_set_ready_n, ring_indicator_n;
   logic       carrier_detect_n, sample_tick, modem_irq;
   int         num_errors, cmp_count, n, i;
   int         m [8];

   uart_status_baud dut_u (
      .clk(clk), .reset_n(reset_n), .por_n(por_n), .addr(addr),
      .rd_en(rd_en), .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data),
      .line_control(line_control), .modem_control(modem_control),
      .enhanced_feature_control(enhanced_feature_control),
      .modem_int_enable(modem_int_enable),
      .rx_fifo_nonempty(rx_fifo_nonempty), .rx_fifo_full(rx_fifo_full),
      .rx_char_arrived(rx_char_arrived),
      .rx_head_parity_err(rx_head_parity_err),
      .rx_head_framing_err(rx_head_framing_err),
      .rx_head_break(rx_head_break), .rx_any_error(rx_any_error),
      .clear_to_send_n(clear_to_send_n), .data_set_ready_n(data_set_ready_n),
      .ring_indicator_n(ring_indicator_n), .carrier_detect_n(carrier_detect_n),
      .rx_fifo_write(rx_fifo_write), .irda_mode(irda_mode),
      .rs485_auto(rs485_auto), .sample_tick(sample_tick), .modem_irq(modem_irq)
   );

   uart_host_model host_u (
      .clk(clk), .addr(addr), .rd_en(rd_en), .wr_en(wr_en),
      .wr_data(wr_data), .rd_data(rd_data)
   );

   always #10 clk = ~clk;

   task automatic final_report;
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got,
                  exp);
      end
   endtask

   task automatic rdchk(input logic [2:0] a, input logic [7:0] e, mask);
      host_u.rd(a, r);
      chk(r & mask, e & mask, $sformatf("read offset %0d", a));
   endtask

   task automatic ctl(input logic [7:0] l, c, e);
      @(posedge clk);
      line_control <= l;
      modem_control <= c;
      enhanced_feature_control <= e;
   endtask

   // Pins {carrier, ring, dsr, cts}; settle lets deltas reach the irq flop
   task automatic pins(input logic [3:0] p);
      @(posedge clk);
      {carrier_detect_n, ring_indicator_n} <= p[3:2];
      {data_set_ready_n, clear_to_send_n} <= p[1:0];
      repeat (4) @(posedge clk);
   endtask

   // Write through a window; refused writes read 00 there and keep the model
   task automatic win(input logic [2:0] a, input logic [7:0] l, c, e,
                      input bit ok, input logic [7:0] rl, re);
      v = 8'($urandom);
      ctl(l, c, e);
      host_u.wr(a, v);
      if (ok) begin
         m[a] = v;
      end else begin
         rdchk(a, 8'h00, 8'hFF);
      end
      ctl(rl, 8'h00, re);
      rdchk(a, 8'(m[a]), 8'hFF);
   endtask

   task automatic gap(output int k);
      k = 0;
      do begin
         @(posedge clk);
         #1;
         k++;
      end while (sample_tick !== 1'b1 && k < 3000);
   endtask

   initial begin
      #(20 * 60000);
      num_errors++;
      final_report();
   end

   initial begin
      void'($urandom(51));
      {clk, reset_n, por_n, modem_int_enable} = 4'h0;
      {line_control, modem_control, enhanced_feature_control} = 24'h0;
      {rx_fifo_nonempty, rx_fifo_full, rx_char_arrived} = 3'h0;
      {rx_head_parity_err, rx_head_framing_err, rx_head_break} = 3'h0;
      rx_any_error = 1'b0;
      v = 8'($urandom);
      {carrier_detect_n, ring_indicator_n} = v[3:2];
      {data_set_ready_n, clear_to_send_n} = v[1:0];
      m = '{1, 0, 0, 0, 0, 0, 0, 255};
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      por_n <= 1'b1;
      repeat (4) @(posedge clk);
      rdchk(OFS_MODEM, {~v[3:0], 4'h0}, 8'hF0);
      ctl(8'h80, 8'h00, 8'h10);
      rdchk(OFS_DIV_LOW, RST_DIV_LOW, 8'hFF);
      rdchk(OFS_DIV_HIGH, RST_DIV_HIGH, 8'hFF);
      rdchk(OFS_RATE_MODE, RST_RATE_MODE, 8'hFF);
      ctl(8'h03, 8'h00, 8'h00);
      rdchk(OFS_SCRATCH, RST_SCRATCH, 8'hFF);
      win(OFS_SCRATCH, 8'h03, 8'h00, 8'h00, 1, 8'h00, 8'h00);
      win(OFS_SCRATCH, 8'h80, 8'h00, 8'h00, 0, 8'h00, 8'h00);
      win(OFS_SCRATCH, 8'h00, 8'h40, 8'h00, 0, 8'h00, 8'h00);
      win(OFS_DIV_LOW, 8'h83, 8'h00, 8'h00, 1, 8'h80, 8'h00);
      win(OFS_DIV_HIGH, 8'h80, 8'h00, 8'h00, 1, 8'h80, 8'h00);
      win(OFS_DIV_LOW, 8'hBF, 8'h00, 8'h00, 0, 8'h80, 8'h00);
      win(OFS_DIV_HIGH, 8'h00, 8'h00, 8'h00, 0, 8'h80, 8'h00);
      win(OFS_RATE_MODE, 8'h80, 8'h00, 8'h00, 0, 8'h80, 8'h10);
      win(OFS_RATE_MODE, 8'h00, 8'h00, 8'h10, 0, 8'h80, 8'h10);
      for (i = 0; i < 4; i++) begin
         win(OFS_RATE_MODE, 8'hBF, 8'h00, 8'h10, 1, 8'h80, 8'h10);
         chk({7'h0, irda_mode}, {7'h0, m[2][7]}, "infrared");
         chk({7'h0, rs485_auto}, {7'h0, m[2][6]}, "auto dir");
      end
      // Plain reset leaves divisor alone, restores scratch and mode
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk({7'h0, irda_mode}, 8'h00, "infrared after reset");
      rdchk(OFS_DIV_LOW, 8'(m[0]), 8'hFF);
      rdchk(OFS_DIV_HIGH, 8'(m[1]), 8'hFF);
      ctl(8'h00, 8'h00, 8'h00);
      rdchk(OFS_SCRATCH, RST_SCRATCH, 8'hFF);
      for (i = 0; i < 8; i++) begin
         v = 8'($urandom);
         @(posedge clk);
         {rx_any_error, rx_head_break, rx_head_framing_err} <= v[4:2];
         {rx_head_parity_err, rx_fifo_nonempty} <= v[1:0];
         r = {v[4], 2'h0, v[3:1] & {3{v[0]}}, 1'b0, v[0]};
         rdchk(OFS_RX_STATE, r, 8'h9F);
      end
      // Arrival into a full FIFO is dropped and flagged
      for (i = 0; i < 2; i++) begin
         @(posedge clk);
         rx_fifo_full <= (i == 0);
         rx_char_arrived <= 1'b1;
         @(posedge clk);
         rx_char_arrived <= 1'b0;
         #1;
         chk({7'h0, rx_fifo_write}, 8'(i), "fifo write");
         rdchk(OFS_RX_STATE, {6'h0, ~i[0], 1'b0}, 8'h02);
      end
      for (i = 0; i < 8; i++) begin
         v = 8'($urandom) & 8'h1C;
         ctl(8'h00, v, 8'h00);
         pins(4'($urandom));
         r = v[4] ? {v[3:2], 6'h0} : {~carrier_detect_n, ~ring_indicator_n,
                                      ~data_set_ready_n, ~clear_to_send_n, 4'h0};
         rdchk(OFS_MODEM, r, v[4] ? 8'hC0 : 8'hF0);
      end
      // Change flags and interrupt, enabled then disabled
      ctl(8'h00, 8'h00, 8'h00);
      for (i = 0; i < 2; i++) begin
         modem_int_enable <= (i == 0);
         r = {~carrier_detect_n, ~ring_indicator_n, ~data_set_ready_n,
              ~clear_to_send_n, 4'h0};
         rdchk(OFS_MODEM, r, 8'hF0);
         v = {4'h0, carrier_detect_n, ring_indicator_n, data_set_ready_n,
              clear_to_send_n};
         pins(i == 0 ? v[3:0] ^ 4'h2 : v[3:0] ^ 4'h1);
         chk({7'h0, modem_irq}, 8'(i == 0), "modem irq");
         rdchk(OFS_MODEM, i == 0 ? 8'h02 : 8'h01, 8'h03);
      end
      // Tick spacing for divisor 0 under both prescales, then 2 without and 3 to 6 with prescale
      for (i = 0; i < 4; i++) begin
         v = i < 2 ? 8'h00 : (i == 2 ? 8'h02 : 8'(3 + $urandom % 4));
         ctl(8'h80, 8'h00, 8'h10);
         host_u.wr(OFS_DIV_LOW, v);
         host_u.wr(OFS_DIV_HIGH, 8'h00);
         ctl(8'h80, {i[0], 7'h0}, 8'h10);
         gap(n);
         gap(n);
         gap(n);
         chk(8'(n), 8'((v == 0 ? 1 : v) * (i[0] ? 4 : 1)), "tick");
      end
      final_report();
   end
endmodule // uart_status_baud_test
